// File: dgs_pkg.sv
// Package: register map, field positions, reset values and timing of the gain/status bank
package dgs_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [4:0] ADDR_GAIN_STATUS = 5'h0A;
	localparam logic [4:0] ADDR_STORED_GAIN = 5'h1A;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int GAIN_LSB = 8;
	localparam int POR_FLAG_BIT = 7;
	localparam int NVWA_BIT = 6;
	localparam int LOCK_BIT = 7;

	// ----------------------------------------
	// Reset values and encodings
	// ----------------------------------------
	localparam logic [1:0] VOL_GAIN_RST = 2'h0;
	localparam logic POR_FLAG_RST = 1'b1;
	localparam logic [1:0] NV_GAIN_RST = 2'h0;
	localparam logic [6:0] NV_ADDR_RST = 7'h30;
	localparam logic [1:0] REF_SEL_VDD = 2'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int NV_WRITE_TIME_US = 5000;
	localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_MHZ;
	localparam int CNT_W = 20;

	typedef enum logic [2:0]
	{
		ST_LOAD = 3'b001,
		ST_IDLE = 3'b010,
		ST_NVWR = 3'b100
	} dgs_state_e;

endpackage : dgs_pkg

// File: dgs_regs.sv
// Module: gain, status and stored slave address registers of the converter
// Functional notes
// RULE1: Bit 8 selects double gain on channel 0 when set; resets to zero.
// RULE2: Bit 9 is channel 1 gain on dual parts, reads zero on single parts.
// RULE3: Reference select 00 forces unity gain regardless of the gain bit.
// RULE4: Bit 7 reset event flag sets on power-on or brown-out, holds until read.
// RULE5: Reading the gain and status register clears the reset event flag.
// RULE6: Bit 6 reads one while a nonvolatile write cycle runs.
// RULE7: During a nonvolatile write only volatile commands are accepted.
// RULE8: Unimplemented bits of the gain and status register read zero.
// RULE9: Register 0x1A stores gain bits kept across power cycles, same encoding.
// RULE10: Bits 6-0 of 0x1A hold the 7-bit bus slave address used for matching.
// RULE11: Bit 7 of 0x1A is read-only and mirrors the address lock configuration.
// RULE12: While locked, slave address changes are refused; unlock needs high voltage command.
// RULE13: With lock status zero, the stored slave address may be rewritten.
// RULE14: Reference select 00 means supply as unbuffered reference, buffer disabled.
// RULE15: After power-on or brown-out, volatile gains load from stored copies first.
module dgs_regs
	import dgs_pkg::*;
#(
	parameter bit DUAL_CH = 1'b1,
	parameter int unsigned NV_WRITE_CYC = dgs_pkg::NV_WRITE_CYCLES
)
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Supply events
	input wire logic por_event_i,
	// Register access from the serial interface
	input wire logic [4:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_ack_o,
	output logic reg_nack_o,
	// Configuration from neighbouring registers
	input wire logic [3:0] reference_select_i,
	input wire logic address_lock_config_i,
	input wire logic high_voltage_unlock_i,
	// Status and control outputs
	output logic [1:0] chan_gain_o,
	output logic [6:0] slave_address_bits_o,
	output logic nv_write_active_o,
	output logic address_lock_status_o,
	output logic ready_o
);
	import dgs_pkg::*;

	localparam logic [1:0] GAIN_MASK = DUAL_CH ? 2'h3 : 2'h1;
	localparam logic [CNT_W-1:0] NV_CNT_LOAD = NV_WRITE_CYC[CNT_W-1:0];

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic eff_gain(input logic [1:0] ref_sel, input logic gain_sel);
		// Supply reference is unbuffered and only allows unity gain
		eff_gain = (ref_sel == REF_SEL_VDD) ? 1'b0 : gain_sel; // RULE3 RULE14
	endfunction : eff_gain

	function automatic logic hits(input logic [4:0] addr, input logic [4:0] reg_addr);
		hits = (addr == reg_addr);
	endfunction : hits

	// ----------------------------------------
	// State
	// ----------------------------------------
	dgs_state_e state_q, state_d;
	logic [1:0] vol_gain_q, vol_gain_d;
	logic por_flag_q, por_flag_d;
	logic [1:0] nv_gain_q, nv_gain_d;
	logic [6:0] nv_addr_q, nv_addr_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [15:0] rdata_q, rdata_d;
	logic ack_q, ack_d;
	logic nack_q, nack_d;
	logic [1:0] gain_out_q, gain_out_d;
	logic nvwa_q, nvwa_d;
	logic lock_q;
	logic ready_q, ready_d;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		state_d = state_q;
		vol_gain_d = vol_gain_q;
		por_flag_d = por_flag_q;
		nv_gain_d = nv_gain_q;
		nv_addr_d = nv_addr_q;
		cnt_d = cnt_q;
		rdata_d = 16'h0000;
		ack_d = 1'b0;
		nack_d = 1'b0;
		case (state_q)
			ST_LOAD:
			begin
				vol_gain_d = nv_gain_q & GAIN_MASK; // RULE15 RULE9
				state_d = ST_IDLE;
			end
			ST_IDLE:
			begin
				cnt_d = cnt_q;
			end
			ST_NVWR:
			begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q <= 1)
				begin
					state_d = ST_IDLE;
				end
			end
			default:
			begin
				state_d = ST_LOAD;
			end
		endcase
		if (reg_rd_i || reg_wr_i)
		begin
			if (state_q == ST_LOAD)
			begin
				nack_d = 1'b1;
			end
			else if (hits(reg_addr_i, ADDR_GAIN_STATUS))
			begin
				ack_d = 1'b1;
				if (reg_wr_i)
				begin
					vol_gain_d = reg_wdata_i[GAIN_LSB +: 2] & GAIN_MASK; // RULE1 RULE2
				end
				if (reg_rd_i)
				begin
					// Unlisted bits stay zero
					rdata_d[GAIN_LSB +: 2] = vol_gain_q; // RULE8
					rdata_d[POR_FLAG_BIT] = por_flag_q;
					rdata_d[NVWA_BIT] = (state_q == ST_NVWR); // RULE6
					por_flag_d = 1'b0; // RULE5
				end
			end
			else if (hits(reg_addr_i, ADDR_STORED_GAIN))
			begin
				if (state_q == ST_NVWR)
				begin
					nack_d = 1'b1; // RULE7
				end
				else
				begin
					ack_d = 1'b1;
					if (reg_rd_i)
					begin
						rdata_d[GAIN_LSB +: 2] = nv_gain_q;
						rdata_d[LOCK_BIT] = lock_q; // RULE11
						rdata_d[6:0] = nv_addr_q; // RULE10
					end
					if (reg_wr_i)
					begin
						nv_gain_d = reg_wdata_i[GAIN_LSB +: 2] & GAIN_MASK; // RULE9
						if (!lock_q || high_voltage_unlock_i)
						begin
							nv_addr_d = reg_wdata_i[6:0]; // RULE12 RULE13
						end
						state_d = ST_NVWR;
						cnt_d = NV_CNT_LOAD;
					end
				end
			end
			else
			begin
				nack_d = 1'b1;
			end
		end
		// A new supply event wins over a read clear
		if (por_event_i)
		begin
			por_flag_d = 1'b1; // RULE4
			state_d = ST_LOAD;
		end
		gain_out_d[0] = eff_gain(reference_select_i[1:0], vol_gain_d[0]); // RULE3
		gain_out_d[1] = eff_gain(reference_select_i[3:2], vol_gain_d[1]) & DUAL_CH; // RULE2
		nvwa_d = (state_d == ST_NVWR); // RULE6
		ready_d = (state_d != ST_LOAD);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			state_q <= ST_LOAD;
			vol_gain_q <= VOL_GAIN_RST;
			por_flag_q <= POR_FLAG_RST;
			nv_gain_q <= NV_GAIN_RST;
			nv_addr_q <= NV_ADDR_RST;
			cnt_q <= '0;
			rdata_q <= 16'h0000;
			ack_q <= 1'b0;
			nack_q <= 1'b0;
			gain_out_q <= 2'h0;
			nvwa_q <= 1'b0;
			lock_q <= 1'b0;
			ready_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			vol_gain_q <= vol_gain_d;
			por_flag_q <= por_flag_d;
			nv_gain_q <= nv_gain_d;
			nv_addr_q <= nv_addr_d;
			cnt_q <= cnt_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
			nack_q <= nack_d;
			gain_out_q <= gain_out_d;
			nvwa_q <= nvwa_d;
			lock_q <= address_lock_config_i; // RULE11
			ready_q <= ready_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign reg_ack_o = ack_q;
	assign reg_nack_o = nack_q;
	assign chan_gain_o = gain_out_q;
	assign slave_address_bits_o = nv_addr_q;
	assign nv_write_active_o = nvwa_q;
	assign address_lock_status_o = lock_q;
	assign ready_o = ready_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence s_nv_start;
		state_q == ST_IDLE && reg_wr_i && hits(reg_addr_i, ADDR_STORED_GAIN) && !por_event_i;
	endsequence

	sequence s_status_read;
		state_q != ST_LOAD && reg_rd_i && hits(reg_addr_i, ADDR_GAIN_STATUS) && !por_event_i;
	endsequence

	a_gain0_follow: assert property ($past(reference_select_i[1:0]) != REF_SEL_VDD |-> chan_gain_o[0] == vol_gain_q[0]) // RULE1
		else $error("channel 0 gain does not follow its select bit");
	a_gain1_single: assert property (!DUAL_CH |-> vol_gain_q[1] == 1'b0 && chan_gain_o[1] == 1'b0) // RULE2
		else $error("channel 1 gain set on single channel part");
	a_gain_vdd_unity: assert property (reference_select_i[1:0] == REF_SEL_VDD |=> !chan_gain_o[0]) // RULE3
		else $error("double gain with supply reference");
	a_por_set_hold: assert property (por_event_i ##1 !(reg_rd_i && hits(reg_addr_i, ADDR_GAIN_STATUS)) |=> por_flag_q) // RULE4
		else $error("reset event flag not held after supply event");
	a_por_read_clear: assert property (s_status_read |=> !por_flag_q && reg_ack_o && reg_rdata_o[POR_FLAG_BIT] == $past(por_flag_q)) // RULE5
		else $error("status read did not clear reset event flag");
	a_nvwa_busy: assert property (s_nv_start |=> nv_write_active_o [*8]) // RULE6
		else $error("write active flag not raised for stored write");
	a_nv_refused: assert property (state_q == ST_NVWR && reg_wr_i && hits(reg_addr_i, ADDR_STORED_GAIN) && !por_event_i
		|=> reg_nack_o && $stable(nv_addr_q) && $stable(nv_gain_q)) // RULE7
		else $error("stored write accepted during write cycle");
	a_unimpl_zero: assert property (reg_ack_o |-> reg_rdata_o[15:10] == 6'h00 && (reg_rdata_o[9] == 1'b0 || DUAL_CH)) // RULE8
		else $error("unimplemented bits read nonzero");
	a_addr_rewrite: assert property (s_nv_start and !lock_q |=> slave_address_bits_o == $past(reg_wdata_i[6:0])) // RULE13
		else $error("unlocked address not rewritten");
	a_addr_locked: assert property (s_nv_start and lock_q && !high_voltage_unlock_i |=> $stable(slave_address_bits_o)) // RULE12
		else $error("locked address changed");
	a_lock_mirror: assert property (state_q == ST_IDLE && reg_rd_i && hits(reg_addr_i, ADDR_STORED_GAIN) && !por_event_i
		|=> reg_rdata_o[LOCK_BIT] == $past(address_lock_config_i, 2) && reg_rdata_o[6:0] == $past(slave_address_bits_o)) // RULE11
		else $error("lock status bit does not mirror configuration");
	a_load_stored: assert property (state_q == ST_LOAD && !por_event_i |=> vol_gain_q == ($past(nv_gain_q) & GAIN_MASK) && ready_o) // RULE15
		else $error("volatile gain not loaded from stored copy");

endmodule : dgs_regs

// File: dgs_host.sv
// Host model driving the register port of the gain/status bank
module dgs_host
(
	// Clock
	input wire logic core_clk_i,
	// Register port
	output logic [4:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [15:0] reg_wdata_o,
	input wire logic [15:0] reg_rdata_i,
	input wire logic reg_ack_i,
	input wire logic reg_nack_i
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		reg_addr_o = 5'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 16'h0000;
	end

	// ----
	// One access: strobe for one edge, answer one cycle later
	// ----
	// Caller must wait out the write cycle before stored-word accesses
	task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d,
		output logic [15:0] rdata, output logic ack, output logic nack);
		@(posedge core_clk_i);
		reg_wr_o <= wr;
		reg_rd_o <= ~wr;
		reg_addr_o <= a;
		reg_wdata_o <= d;
		@(posedge core_clk_i);
		reg_wr_o <= 1'b0;
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
		#1;
		rdata = reg_rdata_i;
		ack = reg_ack_i;
		nack = reg_nack_i;
	endtask : acc
endmodule : dgs_host

// File: testbench.sv
// Self-checking bench for the gain/status register bank
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import dgs_pkg::*;

	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic por_event_i = 1'b0;
	logic [4:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata_o;
	logic reg_ack_o;
	logic reg_nack_o;
	logic [3:0] reference_select_i = 4'hF;
	logic address_lock_config_i = 1'b0;
	logic high_voltage_unlock_i = 1'b0;
	logic [1:0] chan_gain_o;
	logic [6:0] slave_address_bits_o;
	logic nv_write_active_o;
	logic address_lock_status_o;
	logic ready_o;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;

	always #2.5 core_clk_i = ~core_clk_i;

	dgs_regs #(.DUAL_CH(1'b1), .NV_WRITE_CYC(10)) i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.por_event_i(por_event_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .reg_nack_o(reg_nack_o),
		.reference_select_i(reference_select_i), .address_lock_config_i(address_lock_config_i),
		.high_voltage_unlock_i(high_voltage_unlock_i), .chan_gain_o(chan_gain_o),
		.slave_address_bits_o(slave_address_bits_o), .nv_write_active_o(nv_write_active_o),
		.address_lock_status_o(address_lock_status_o), .ready_o(ready_o));

	dgs_host i_host (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
		.reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata_o), .reg_ack_i(reg_ack_o), .reg_nack_i(reg_nack_o));

	// ----
	// Compare and wait helpers
	// ----
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk16

	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk1

	task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d, input logic [15:0] exp,
		input logic exp_ack);
		logic [15:0] rdata;
		logic ack;
		logic nack;
		i_host.acc(wr, a, d, rdata, ack, nack);
		chk1(ack, exp_ack);
		chk1(nack, ~exp_ack);
		if (!wr && exp_ack)
			chk16(rdata, exp);
	endtask : xfer

	task automatic wait_rdy();
		for (int i = 0; i < 40 && ready_o !== 1'b1; i++)
		begin
			@(posedge core_clk_i);
			#1;
		end
		chk1(ready_o, 1'b1);
	endtask : wait_rdy

	task automatic wait_nv();
		for (int i = 0; i < 40 && nv_write_active_o !== 1'b0; i++)
		begin
			@(posedge core_clk_i);
			#1;
		end
		chk1(nv_write_active_o, 1'b0);
	endtask : wait_nv

	task automatic set_gain_ref(input logic [3:0] sel, input logic [1:0] exp);
		@(posedge core_clk_i);
		reference_select_i <= sel;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk16({14'h0000, chan_gain_o}, {14'h0000, exp});
	endtask : set_gain_ref

	task automatic give_verdict();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	always @(posedge core_clk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			$display("[FAIL] %0t timeout", $time);
			give_verdict();
		end
	end

	// ----
	// Test sequence
	// ----
	initial
	begin
		repeat (10) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		wait_rdy();
		xfer(1'b0, ADDR_GAIN_STATUS, 16'h0000, 16'h0080, 1'b1);
		xfer(1'b0, ADDR_GAIN_STATUS, 16'h0000, 16'h0000, 1'b1);
		xfer(1'b1, ADDR_GAIN_STATUS, 16'hFFFF, 16'h0000, 1'b1);
		xfer(1'b0, ADDR_GAIN_STATUS, 16'h0000, 16'h0300, 1'b1);
		set_gain_ref(4'hF, 2'h3);
		set_gain_ref(4'hC, 2'h2);
		set_gain_ref(4'h3, 2'h1);
		xfer(1'b1, ADDR_STORED_GAIN, 16'h0155, 16'h0000, 1'b1);
		chk1(nv_write_active_o, 1'b1);
		xfer(1'b0, ADDR_GAIN_STATUS, 16'h0000, 16'h0340, 1'b1);
		xfer(1'b0, ADDR_STORED_GAIN, 16'h0000, 16'h0000, 1'b0);
		xfer(1'b1, ADDR_STORED_GAIN, 16'h03FF, 16'h0000, 1'b0);
		wait_nv();
		xfer(1'b0, ADDR_STORED_GAIN, 16'h0000, 16'h0155, 1'b1);
		chk16({9'h000, slave_address_bits_o}, 16'h0055);
		@(posedge core_clk_i);
		address_lock_config_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1;
		chk1(address_lock_status_o, 1'b1);
		xfer(1'b0, ADDR_STORED_GAIN, 16'h0000, 16'h01D5, 1'b1);
		xfer(1'b1, ADDR_STORED_GAIN, 16'h0022, 16'h0000, 1'b1);
		wait_nv();
		xfer(1'b0, ADDR_STORED_GAIN, 16'h0000, 16'h00D5, 1'b1);
		@(posedge core_clk_i);
		high_voltage_unlock_i <= 1'b1;
		xfer(1'b1, ADDR_STORED_GAIN, 16'h0122, 16'h0000, 1'b1);
		wait_nv();
		@(posedge core_clk_i);
		high_voltage_unlock_i <= 1'b0;
		xfer(1'b0, ADDR_STORED_GAIN, 16'h0000, 16'h01A2, 1'b1);
		xfer(1'b0, 5'h05, 16'h0000, 16'h0000, 1'b0);
		@(posedge core_clk_i);
		por_event_i <= 1'b1;
		@(posedge core_clk_i);
		por_event_i <= 1'b0;
		#1;
		chk1(ready_o, 1'b0);
		wait_rdy();
		xfer(1'b0, ADDR_GAIN_STATUS, 16'h0000, 16'h0180, 1'b1);
		give_verdict();
	end
endmodule : testbench
